//--- shared/ptp_event_defs.vh
// register map, field positions, command codes and timing constants of the event i/o block
`ifndef PTP_EVENT_DEFS_VH
`define PTP_EVENT_DEFS_VH

`define REG_GEN_CTRL 8'h00
`define REG_GEN_CMD 8'h04
`define REG_STAMP_CTRL 8'h08
`define REG_STAMP_DIV 8'h0C
`define REG_LIVE 8'h10
`define REG_LATCHED 8'h14
`define REG_READ_CMD 8'h18
`define REG_WORD1 8'h1C
`define REG_WORD2 8'h20
`define REG_WORD3 8'h24
`define REG_WORD4 8'h28
`define REG_WORD5 8'h2C
`define REG_TIME_NS 8'h30
`define REG_TIME_SEC 8'h34

`define CTL_HOLD 0
`define CTL_FINE 1
`define CTL_GRST 2
`define SC_SRC_LSB 8
`define SC_DIV1_EN 16
`define SC_DIV2_EN 17
`define RO_POL_BIT 15

`define GEN_CTRL_RST 3'h0
`define STAMP_CTRL_RST 32'h0000_0000
`define STAMP_DIV_RST 32'h0000_0000

`define CMD_REPEAT 4'h0
`define CMD_FRAC 4'h1
`define CMD_SETREF 4'h2
`define FORM_ABS 2'h1
`define FORM_REL32 2'h2
`define FORM_REL16 2'h3
`define ACT_RISE 2'h1
`define ACT_FALL 2'h2

`define CLK_NS 30'h0000_0064
`define PHASES 30'h0000_0008
`define PHASE_NS (`CLK_NS / `PHASES)
`define ONE_SEC_NS 30'h3B9A_CA00
`define ONE_SEC_NF 40'h3B_9ACA_0000

`endif

//--- rtl/ptp_event_io.v
// edge generator and input timestampers with their register port
// Notes on behaviour
// - fractional groups interleave first and second pair repeats in sixteenth portions
// - each pair repeats exactly its programmed count, even if not a multiple of 16
// - fastest output is one edge per four clock cycles, an eighth of the clock rate
// - command nibble f toggles at a 16-bit relative time
// - command nibble e toggles at a 32-bit relative time, upper half first
// - nibble 5 takes five words of absolute time, then places a rising edge
// - repeat command loops over the preceding n entries until a new command
// - fine resolution makes relative offsets count in 1/256 ns
// - three timestampers capture rising, falling or both edges of their input
// - bit 15 of readout word five gives the captured edge polarity
// - each timestamper owns an eight entry stamp store
// - store overflow sets a latched overflow bit per timestamper
// - a live bit shows whether each store holds entries
// - empty to not-empty transition sets a latched not-empty bit
// - first timestamper input passes two dividers, single or cascaded
// - stamps resolve below a clock period using eight sample phases
// - advance hold keeps the current group running but blocks the next command
// - relative commands need a prior absolute or set-reference command
// - generator reset empties the command store, loads control from the written bits, drives output low
`timescale 1ns/100ps
`include "ptp_event_defs.vh"

module ptp_event_io #(
    parameter CMD_DEPTH = 16,
    parameter AW = 4,
    parameter STAMP_DEPTH = 8,
    parameter NPINS = 4
) (
    input wire clock,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire [NPINS*8-1:0] pin_samples,
    output reg edge_out
);
    localparam G_FETCH = 3'd0;
    localparam G_WORDS = 3'd1;
    localparam G_NORM = 3'd2;
    localparam G_WAIT = 3'd3;
    localparam G_FRAC = 3'd4;
    localparam [AW-1:0] ONE = 1;
    localparam [AW-1:0] TWO = 2;
    localparam [AW-1:0] FOUR = 4;

    function [7:0] portion;
        input [7:0] m;
        input [3:0] k;
        reg [11:0] hi;
        reg [11:0] lo;
        begin
            hi = {4'h0, m} * ({8'h00, k} + 12'h001);
            lo = {4'h0, m} * {8'h00, k};
            portion = hi[11:4] - lo[11:4];
        end
    endfunction

    function [3:0] first_edge;
        input [7:0] smp;
        input prev;
        integer i;
        reg lvl;
        reg done;
        begin
            first_edge = 4'h0;
            lvl = prev;
            done = 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                if (!done && smp[i] != lvl) begin
                    first_edge = {1'b1, i[2:0]};
                    done = 1'b1;
                end
                lvl = smp[i];
            end
        end
    endfunction

    // time engine
    reg [47:0] now_sec;
    reg [29:0] now_ns;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            now_sec <= 48'h0000_0000_0000;
            now_ns <= 30'h0000_0000;
        end else if (now_ns + `CLK_NS >= `ONE_SEC_NS) begin
            now_ns <= now_ns + `CLK_NS - `ONE_SEC_NS;
            now_sec <= now_sec + 48'h0000_0000_0001;
        end else begin
            now_ns <= now_ns + `CLK_NS;
        end
    end

    // register strobes
    wire w_ctrl = wr && addr == `REG_GEN_CTRL;
    wire cmd_push = wr && addr == `REG_GEN_CMD;
    wire gen_rst = w_ctrl && wdata[`CTL_GRST];
    reg [2:0] gen_ctrl;
    reg [31:0] stamp_ctrl;
    reg [31:0] stamp_div;
    wire advance_hold = gen_ctrl[`CTL_HOLD];
    wire fine_resolution_sel = gen_ctrl[`CTL_FINE];

    // edge generator state
    reg [19:0] cmem [0:CMD_DEPTH-1];
    reg [AW-1:0] wp;
    reg [AW-1:0] ptr;
    reg [AW-1:0] loop_base;
    reg [AW-1:0] loop_end;
    reg loop_active;
    reg frac_mode;
    reg pair;
    reg [3:0] k;
    reg [7:0] rem;
    reg [7:0] repeat_count_first;
    reg [7:0] repeat_count_second;
    reg [2:0] gstate;
    reg [2:0] need;
    reg [79:0] acc;
    reg [1:0] action;
    reg [1:0] form;
    reg ref_valid;
    reg [47:0] tsec;
    reg [39:0] tnf;

    wire [19:0] cur_word = cmem[ptr];
    wire [3:0] cur_cmd = cur_word[19:16];
    wire [AW-1:0] after_end = loop_end + ONE;
    wire [AW-1:0] tail = loop_active ? loop_base : ptr;
    wire cmd_full = (wp + ONE) == tail;
    wire leave_ok = (wp != after_end) && !advance_hold;
    wire [AW-1:0] seg_start = pair ? loop_base + TWO : loop_base;
    wire [AW-1:0] seg_end = pair ? loop_end : loop_base + TWO;
    wire [31:0] rel = (form == `FORM_REL32) ? acc[31:0] : {16'h0000, acc[15:0]};
    wire [39:0] rel_off = fine_resolution_sel ? {8'h00, rel} : {rel, 8'h00};
    wire reached = {now_sec, now_ns, 8'h00} >= {tsec, tnf[37:0]};

    always @(posedge clock) begin
        if (cmd_push && !cmd_full) begin
            cmem[wp] <= wdata[19:0];
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wp <= {AW{1'b0}};
            ptr <= {AW{1'b0}};
            loop_base <= {AW{1'b0}};
            loop_end <= {AW{1'b0}};
            loop_active <= 1'b0;
            frac_mode <= 1'b0;
            pair <= 1'b0;
            k <= 4'h0;
            rem <= 8'h00;
            repeat_count_first <= 8'h00;
            repeat_count_second <= 8'h00;
            gstate <= G_FETCH;
            need <= 3'h0;
            acc <= 80'h0;
            action <= 2'h0;
            form <= 2'h0;
            ref_valid <= 1'b0;
            tsec <= 48'h0000_0000_0000;
            tnf <= 40'h00_0000_0000;
            edge_out <= 1'b0;
        end else if (gen_rst) begin
            wp <= {AW{1'b0}};
            ptr <= {AW{1'b0}};
            loop_active <= 1'b0;
            frac_mode <= 1'b0;
            gstate <= G_FETCH;
            ref_valid <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            if (cmd_push && !cmd_full) begin
                wp <= wp + ONE;
            end
            case (gstate)
                G_FETCH: begin
                    if (loop_active && frac_mode && ptr == seg_end) begin
                        if (rem > 8'h01) begin
                            rem <= rem - 8'h01;
                            ptr <= seg_start;
                        end else begin
                            rem <= 8'h00;
                            gstate <= G_FRAC;
                        end
                    end else if (loop_active && !frac_mode && ptr == loop_end) begin
                        if (leave_ok) begin
                            loop_active <= 1'b0;
                            ptr <= after_end;
                        end else begin
                            ptr <= loop_base;
                        end
                    end else if (ptr != wp && (loop_active || !advance_hold)) begin
                        ptr <= ptr + ONE;
                        if (cur_cmd == `CMD_REPEAT) begin
                            if (cur_word[AW-1:0] != {AW{1'b0}}) begin
                                loop_active <= 1'b1;
                                frac_mode <= 1'b0;
                                loop_end <= ptr;
                                loop_base <= ptr - cur_word[AW-1:0];
                                ptr <= ptr - cur_word[AW-1:0];
                            end
                        end else if (cur_cmd == `CMD_FRAC) begin
                            loop_active <= 1'b1;
                            frac_mode <= 1'b1;
                            loop_end <= ptr;
                            loop_base <= ptr - FOUR;
                            repeat_count_first <= cur_word[15:8];
                            repeat_count_second <= cur_word[7:0];
                            pair <= 1'b0;
                            k <= 4'h0;
                            rem <= portion(cur_word[15:8], 4'h0);
                            gstate <= G_FRAC;
                        end else if (cur_cmd == `CMD_SETREF) begin
                            tsec <= now_sec;
                            tnf <= {2'b00, now_ns, 8'h00};
                            ref_valid <= 1'b1;
                        end else if (cur_cmd[3:2] != 2'h0 && cur_cmd[1:0] != 2'h0) begin
                            action <= cur_cmd[3:2];
                            form <= cur_cmd[1:0];
                            acc <= {64'h0, cur_word[15:0]};
                            if (cur_cmd[1:0] == `FORM_ABS) begin
                                need <= 3'h4;
                            end else if (cur_cmd[1:0] == `FORM_REL32) begin
                                need <= 3'h1;
                            end else begin
                                need <= 3'h0;
                            end
                            gstate <= G_WORDS;
                        end
                    end
                end
                G_WORDS: begin
                    if (need != 3'h0) begin
                        if (ptr != wp) begin
                            acc <= {acc[63:0], cur_word[15:0]};
                            ptr <= ptr + ONE;
                            need <= need - 3'h1;
                        end
                    end else if (form == `FORM_ABS) begin
                        tsec <= acc[79:32];
                        tnf <= {2'b00, acc[29:0], 8'h00};
                        ref_valid <= 1'b1;
                        gstate <= G_NORM;
                    end else if (ref_valid) begin
                        tnf <= tnf + rel_off;
                        gstate <= G_NORM;
                    end else begin
                        gstate <= G_FETCH;
                    end
                end
                G_NORM: begin
                    if (tnf >= `ONE_SEC_NF) begin
                        tnf <= tnf - `ONE_SEC_NF;
                        tsec <= tsec + 48'h0000_0000_0001;
                    end else begin
                        gstate <= G_WAIT;
                    end
                end
                G_WAIT: begin
                    // fetch, words, norm and wait take a cycle each, so an edge per four cycles at most
                    if (reached) begin
                        if (action == `ACT_RISE) begin
                            edge_out <= 1'b1;
                        end else if (action == `ACT_FALL) begin
                            edge_out <= 1'b0;
                        end else begin
                            edge_out <= ~edge_out;
                        end
                        gstate <= G_FETCH;
                    end
                end
                G_FRAC: begin
                    if (rem != 8'h00) begin
                        ptr <= seg_start;
                        gstate <= G_FETCH;
                    end else if (!pair) begin
                        pair <= 1'b1;
                        rem <= portion(repeat_count_second, k);
                    end else if (k != 4'hF) begin
                        pair <= 1'b0;
                        k <= k + 4'h1;
                        rem <= portion(repeat_count_first, k + 4'h1);
                    end else if (leave_ok) begin
                        loop_active <= 1'b0;
                        frac_mode <= 1'b0;
                        ptr <= after_end;
                        gstate <= G_FETCH;
                    end else begin
                        pair <= 1'b0;
                        k <= 4'h0;
                        rem <= portion(repeat_count_first, 4'h0);
                    end
                end
                default: gstate <= G_FETCH;
            endcase
        end
    end

    // input edge detection, eight sub-cycle phases per clock
    reg [2:0] prev_lvl;
    reg [2:0] raw_found;
    reg [2:0] raw_last;
    reg [8:0] raw_idx;
    reg [2:0] take;
    reg [2:0] pol;
    reg d1_hit;
    reg d2_hit;
    reg s1_found;
    reg s1_rise;
    reg [15:0] d1_cnt;
    reg [15:0] d2_cnt;
    reg d1_lvl;
    reg d2_lvl;
    reg [3:0] fe;
    reg [7:0] smp;
    reg [1:0] src;
    reg [1:0] esel;
    reg f_found;
    reg f_rise;
    integer s;
    wire [15:0] stamp_divider_first = stamp_div[15:0];
    wire [15:0] stamp_divider_second = stamp_div[31:16];
    wire [15:0] d1_top = (stamp_divider_first == 16'h0000) ? 16'h0000 : stamp_divider_first - 16'h0001;
    wire [15:0] d2_top = (stamp_divider_second == 16'h0000) ? 16'h0000 : stamp_divider_second - 16'h0001;

    always @* begin
        raw_found = 3'h0;
        raw_last = 3'h0;
        raw_idx = 9'h000;
        take = 3'h0;
        pol = 3'h0;
        d1_hit = 1'b0;
        d2_hit = 1'b0;
        s1_found = 1'b0;
        s1_rise = 1'b0;
        fe = 4'h0;
        smp = 8'h00;
        src = 2'h0;
        esel = 2'h0;
        f_found = 1'b0;
        f_rise = 1'b0;
        for (s = 0; s < 3; s = s + 1) begin
            src = stamp_ctrl[`SC_SRC_LSB + 2*s +: 2];
            smp = pin_samples[src*8 +: 8];
            fe = first_edge(smp, prev_lvl[s]);
            raw_found[s] = fe[3];
            raw_idx[s*3 +: 3] = fe[2:0];
            raw_last[s] = smp[7];
            f_found = fe[3];
            f_rise = !prev_lvl[s];
            if (s == 0) begin
                d1_hit = fe[3] && f_rise && d1_cnt >= d1_top;
                s1_found = stamp_ctrl[`SC_DIV1_EN] ? d1_hit : fe[3];
                s1_rise = stamp_ctrl[`SC_DIV1_EN] ? !d1_lvl : f_rise;
                d2_hit = s1_found && s1_rise && d2_cnt >= d2_top;
                f_found = stamp_ctrl[`SC_DIV2_EN] ? d2_hit : s1_found;
                f_rise = stamp_ctrl[`SC_DIV2_EN] ? !d2_lvl : s1_rise;
            end
            esel = stamp_ctrl[2*s +: 2];
            take[s] = f_found && (f_rise ? esel[0] : esel[1]);
            pol[s] = f_rise;
        end
    end

    // stamp stores and register file
    reg [78:0] smem [0:3*STAMP_DEPTH-1];
    reg [8:0] sw_ptr;
    reg [8:0] sr_ptr;
    reg [11:0] scount;
    reg [2:0] stamp_store_not_empty;
    reg [2:0] stamp_store_overflow;
    reg [47:0] ro_sec;
    reg [29:0] ro_ns;
    reg ro_pol;
    wire w_read = wr && addr == `REG_READ_CMD;
    wire w_lat = wr && addr == `REG_LATCHED;
    wire [2:0] live_not_empty;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : live
            assign live_not_empty[g] = scount[g*4 +: 4] != 4'h0;
        end
    endgenerate

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_lvl <= 3'h0;
            d1_cnt <= 16'h0000;
            d2_cnt <= 16'h0000;
            d1_lvl <= 1'b0;
            d2_lvl <= 1'b0;
            sw_ptr <= 9'h000;
            sr_ptr <= 9'h000;
            scount <= 12'h000;
            stamp_store_not_empty <= 3'h0;
            stamp_store_overflow <= 3'h0;
            ro_sec <= 48'h0000_0000_0000;
            ro_ns <= 30'h0000_0000;
            ro_pol <= 1'b0;
            gen_ctrl <= `GEN_CTRL_RST;
            stamp_ctrl <= `STAMP_CTRL_RST;
            stamp_div <= `STAMP_DIV_RST;
        end else begin
            prev_lvl <= raw_last;
            if (w_ctrl) gen_ctrl <= {1'b0, wdata[1:0]};
            if (wr && addr == `REG_STAMP_CTRL) stamp_ctrl <= wdata;
            if (wr && addr == `REG_STAMP_DIV) stamp_div <= wdata;
            if (raw_found[0] && !prev_lvl[0] && stamp_ctrl[`SC_DIV1_EN]) begin
                d1_cnt <= d1_hit ? 16'h0000 : d1_cnt + 16'h0001;
                if (d1_hit) d1_lvl <= ~d1_lvl;
            end
            if (s1_found && s1_rise && stamp_ctrl[`SC_DIV2_EN]) begin
                d2_cnt <= d2_hit ? 16'h0000 : d2_cnt + 16'h0001;
                if (d2_hit) d2_lvl <= ~d2_lvl;
            end
            for (s = 0; s < 3; s = s + 1) begin
                if (take[s] && scount[s*4 +: 4] == STAMP_DEPTH[3:0]) begin
                    stamp_store_overflow[s] <= 1'b1;
                end else if (w_lat && wdata[4+s]) begin
                    stamp_store_overflow[s] <= 1'b0;
                end
                if (take[s] && scount[s*4 +: 4] == 4'h0) begin
                    stamp_store_not_empty[s] <= 1'b1;
                end else if (w_lat && wdata[s]) begin
                    stamp_store_not_empty[s] <= 1'b0;
                end
                if (take[s] && scount[s*4 +: 4] != STAMP_DEPTH[3:0]) begin
                    smem[s*STAMP_DEPTH + sw_ptr[s*3 +: 3]] <=
                        {pol[s], now_sec, now_ns + {27'h0, raw_idx[s*3 +: 3]} * `PHASE_NS};
                    sw_ptr[s*3 +: 3] <= sw_ptr[s*3 +: 3] + 3'h1;
                end
                if (w_read && wdata[1:0] == s[1:0] && scount[s*4 +: 4] != 4'h0) begin
                    {ro_pol, ro_sec, ro_ns} <= smem[s*STAMP_DEPTH + sr_ptr[s*3 +: 3]];
                    sr_ptr[s*3 +: 3] <= sr_ptr[s*3 +: 3] + 3'h1;
                end
                scount[s*4 +: 4] <= scount[s*4 +: 4]
                    + ((take[s] && scount[s*4 +: 4] != STAMP_DEPTH[3:0]) ? 4'h1 : 4'h0)
                    - ((w_read && wdata[1:0] == s[1:0] && scount[s*4 +: 4] != 4'h0) ? 4'h1 : 4'h0);
            end
        end
    end

    // read port, data valid in the cycle after the strobe only
    reg [31:0] rmux;
    always @* begin
        case (addr)
            `REG_GEN_CTRL: rmux = {29'h0, gen_ctrl};
            `REG_STAMP_CTRL: rmux = stamp_ctrl;
            `REG_STAMP_DIV: rmux = stamp_div;
            `REG_LIVE: rmux = {26'h0, edge_out, cmd_full, 1'b0, live_not_empty};
            `REG_LATCHED: rmux = {25'h0, stamp_store_overflow, 1'b0, stamp_store_not_empty};
            `REG_WORD1: rmux = {16'h0000, ro_sec[47:32]};
            `REG_WORD2: rmux = {16'h0000, ro_sec[31:16]};
            `REG_WORD3: rmux = {16'h0000, ro_sec[15:0]};
            `REG_WORD4: rmux = {18'h0, ro_ns[29:16]};
            `REG_WORD5: rmux = {15'h0, ro_ns[15], ro_pol, ro_ns[14:0]};
            `REG_TIME_NS: rmux = {2'b00, now_ns};
            `REG_TIME_SEC: rmux = now_sec[31:0];
            default: rmux = 32'h0000_0000;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rmux : 32'h0000_0000;
        end
    end
endmodule

//--- sim/ptp_event_io_chk.sv
// assertions on the register port and generator output of the event block
`timescale 1ns/100ps
`include "ptp_event_defs.vh"
module ptp_event_io_chk #(
    parameter NPINS = 4
) (
    input wire clock,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire [NPINS*8-1:0] pin_samples,
    input wire edge_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    chk_word5_width: assert property (rd && addr == `REG_WORD5 |=> rdata[31:17] == 15'h0000)
        else $error("readout word five too wide");
    chk_word4_width: assert property (rd && addr == `REG_WORD4 |=> rdata[31:14] == 18'h0_0000)
        else $error("readout word four too wide");
    chk_edge_spacing: assert property ($changed(edge_out) |=> $stable(edge_out))
        else $error("output edges one cycle apart");
    chk_reset_low: assert property (wr && addr == `REG_GEN_CTRL && wdata[`CTL_GRST] |=> !edge_out)
        else $error("generator reset left output high");
    chk_live_unused: assert property (rd && addr == `REG_LIVE |=> rdata[31:6] == 26'h000_0000 && !rdata[3])
        else $error("live status unused bits set");
    chk_latched_unused: assert property (rd && addr == `REG_LATCHED |=> rdata[31:7] == 25'h000_0000 && !rdata[3])
        else $error("latched status unused bits set");
    chk_time_step: assert property ((rd && addr == `REG_TIME_NS) ##1 (rd && addr == `REG_TIME_NS) |=> rdata == $past(rdata) + `CLK_NS)
        else $error("time counter step wrong");
endmodule
bind ptp_event_io ptp_event_io_chk #(.NPINS(NPINS)) u_chk (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_samples(pin_samples), .edge_out(edge_out));

//--- sim/align_source.sv
// alignment source model: phase samples on pin 0, changing noise on unselected pins
`timescale 1ns/100ps
module align_source #(
    parameter NPINS = 4
) (
    input wire clock,
    input wire go,
    input wire [2:0] phase,
    output reg [NPINS*8-1:0] pin_samples = '0
);
    reg level = 1'b0;
    reg [7:0] noise = 8'h00;
    // at most one edge per cycle keeps pulses wide enough in every edge mode
    always @(posedge clock) begin
        noise <= noise + 8'h01;
        level <= level ^ go;
        pin_samples <= {{(NPINS-1){noise}},
            go ? (level ? ~(8'hFF << phase) : (8'hFF << phase)) : {8{level}}};
    end
endmodule

//--- sim/ptp_edge_gen_and_input_stamp_bench.sv
// self-checking bench for the event block
`timescale 1ns/100ps
`include "ptp_event_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module ptp_edge_gen_and_input_stamp_bench;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg go = 1'b0;
    reg [2:0] phase = 3'h0;
    wire [31:0] rdata;
    wire [31:0] pin_samples;
    wire edge_out;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int k, pa, pb, ta, tb;
    reg [31:0] seed = 32'h0001_380A;
    reg [31:0] d, t0;
    reg [29:0] na, nb;
    reg pol;
    reg [7:0] regs [0:5] = '{`REG_GEN_CTRL, `REG_STAMP_CTRL, `REG_STAMP_DIV, `REG_LIVE,
        `REG_LATCHED, 8'h3C};
    ptp_event_io u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pin_samples(pin_samples), .edge_out(edge_out));
    align_source u_src (.clock(clock), .go(go), .phase(phase), .pin_samples(pin_samples));
    always #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    function automatic [31:0] xs(input [31:0] s);
        reg [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int span(int c, int a, int b);
        return c * `CLK_NS + (b - a) * `PHASE_NS;
    endfunction
    task automatic wreg(input [7:0] a, input [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input [7:0] a, output [31:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask
    task automatic pulse(input [2:0] p, output int t);
        @(posedge clock);
        go <= 1'b1;
        phase <= p;
        t = cyc;
        @(posedge clock);
        go <= 1'b0;
    endtask
    task automatic pop(output [29:0] ns, output p);
        reg [31:0] w4, w5;
        wreg(`REG_READ_CMD, 32'h0000_0000);
        rreg(`REG_WORD4, w4);
        rreg(`REG_WORD5, w5);
        ns = {w4[13:0], w5[16], w5[14:0]};
        p = w5[`RO_POL_BIT];
    endtask
    task automatic next_toggle(output int t);
        reg prev;
        int n;
        prev = edge_out;
        for (n = 0; n < 400 && edge_out === prev; n++) @(negedge clock);
        if (n == 400) begin
            failures++;
            wrap_up();
        end
        t = cyc;
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (k = 0; k < 6; k++) begin
            rreg(regs[k], d);
            `CHK(d, 32'h0000_0000)
        end
        wreg(`REG_STAMP_CTRL, 32'h0000_0003);
        for (k = 0; k < 3; k++) begin
            seed = xs(seed);
            pa = seed[2:0];
            pb = seed[5:3];
            pulse(seed[2:0], ta);
            repeat (seed[7:6]) @(posedge clock);
            pulse(seed[5:3], tb);
            repeat (3) @(posedge clock);
            rreg(`REG_LIVE, d);
            `CHK(d[0], 1'b1)
            rreg(`REG_LATCHED, d);
            `CHK(d[0], 1'b1)
            pop(na, pol);
            `CHK(pol, 1'b1)
            pop(nb, pol);
            `CHK(pol, 1'b0)
            `CHK(nb - na, span(tb - ta, pa, pb))
            wreg(`REG_LATCHED, 32'h0000_0077);
        end
        wreg(`REG_STAMP_CTRL, 32'h0000_0001);
        for (k = 0; k < 18; k++) pulse(k[2:0], ta);
        rreg(`REG_LATCHED, d);
        `CHK(d[6:4], 3'h1)
        for (k = 0; k < 8; k++) begin
            pop(na, pol);
            `CHK(pol, 1'b1)
            rreg(`REG_LIVE, d);
            `CHK(d[0], k < 7)
        end
        wreg(`REG_STAMP_CTRL, 32'h0000_0002);
        pulse(3'h5, ta);
        pulse(3'h2, ta);
        repeat (3) @(posedge clock);
        pop(na, pol);
        `CHK(pol, 1'b0)
        rreg(`REG_LIVE, d);
        `CHK(d[0], 1'b0)
        wreg(`REG_STAMP_DIV, 32'h0000_0002);
        wreg(`REG_STAMP_CTRL, 32'h0001_0003);
        for (k = 0; k < 8; k++) pulse(k[2:0], ta);
        repeat (3) @(posedge clock);
        pop(na, pol);
        pop(nb, pol);
        rreg(`REG_LIVE, d);
        `CHK({d[0], pol}, 2'b00)
        wreg(`REG_GEN_CTRL, 32'h0000_0004);
        @(negedge clock);
        `CHK(edge_out, 1'b0)
        wreg(`REG_GEN_CTRL, 32'h0000_0001);
        rreg(`REG_TIME_NS, d);
        t0 = d + 32'h0000_1770;
        ta = cyc;
        for (k = 0; k < 3; k++) wreg(`REG_GEN_CMD, 32'h0005_0000);
        wreg(`REG_GEN_CMD, {12'h005, 2'h0, t0[29:16]});
        wreg(`REG_GEN_CMD, {12'h005, t0[15:0]});
        wreg(`REG_GEN_CMD, 32'h000E_0000);
        wreg(`REG_GEN_CMD, 32'h000E_07D0);
        wreg(`REG_GEN_CMD, 32'h0000_0002);
        `CHK(edge_out, 1'b0)
        wreg(`REG_GEN_CTRL, 32'h0000_0000);
        next_toggle(tb);
        `CHK(tb - ta >= 58 && tb - ta <= 62, 1'b1)
        for (k = 0; k < 2; k++) begin
            ta = tb;
            next_toggle(tb);
            `CHK(tb - ta, 20)
        end
        wreg(`REG_GEN_CMD, 32'h000F_03E8);
        wreg(`REG_GEN_CMD, 32'h0000_0001);
        next_toggle(ta);
        next_toggle(ta);
        next_toggle(tb);
        `CHK(tb - ta, 10)
        wreg(`REG_GEN_CTRL, 32'h0000_0004);
        wreg(`REG_GEN_CTRL, 32'h0000_0002);
        wreg(`REG_GEN_CMD, 32'h0002_0000);
        wreg(`REG_GEN_CMD, 32'h000E_0003);
        wreg(`REG_GEN_CMD, 32'h000E_E800);
        wreg(`REG_GEN_CMD, 32'h0000_0002);
        next_toggle(ta);
        next_toggle(tb);
        `CHK(tb - ta, 10)
        wreg(`REG_GEN_CTRL, 32'h0000_0005);
        wreg(`REG_GEN_CMD, 32'h0002_0000);
        for (k = 0; k < 4; k++) wreg(`REG_GEN_CMD, k < 2 ? 32'h000F_03E8 : 32'h000F_07D0);
        wreg(`REG_GEN_CMD, 32'h0001_1010);
        wreg(`REG_GEN_CTRL, 32'h0000_0000);
        for (k = 0; k < 12; k++) begin
            ta = tb;
            next_toggle(tb);
            if (k > 3) `CHK(tb - ta, k % 4 < 2 ? 10 : 20)
        end
        @(posedge clock);
        addr <= `REG_TIME_NS;
        rd <= 1'b1;
        repeat (2) @(negedge clock);
        d = rdata;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        `CHK(rdata - d, `CLK_NS)
        repeat (2) @(posedge clock);
        wrap_up();
    end
endmodule
